// ### hdl/dtf_trigger_semaphore.v
/*
 * development trigger flag unit: 32 update flags set by cpu and dma over
 * the crossbar, cleared by the calibration tool, a trigger pin, a tool
 * presence word, an enable and an identification word.
 * assumes crossbar signals are on clk; tool pins are asynchronous and
 * the tool clock runs well below clk/4 so every edge is seen.
 */
`timescale 1ns/1ps
`default_nettype none
`include "dtf_consts.vh"

//////////////////////////////////////////////////////////////////////////
// Function
// - thirty-two flags mark refreshed variable sets
// - only cpu and dma may set flags
// - cpu and dma writes never clear flags
// - only tool debug accesses clear flags
// - master number decides set, clear or nothing
// - trigger pin tells tool updates are waiting
// - tool writes presence word, software reads it
// - enable register switches flag setting and trigger pin on
// - identification register readable by the tool
module dtf_trigger_semaphore (
	// clock and reset
	input  wire        clk,
	input  wire        srst,
	// crossbar register port
	input  wire        xbReq,
	input  wire        xbWrite,
	input  wire [2:0]  xbAddr,
	input  wire [31:0] xbWdata,
	input  wire [3:0]  xbMasterId,
	output reg  [31:0] xbRdata,
	output reg         xbAck,
	output reg         xbErr,
	// tool debug serial pins
	input  wire        toolClk,
	input  wire        toolSelN,
	input  wire        toolDi,
	output reg         toolDo,
	output reg         toolDoEn,
	// trigger toward the tool
	output reg         triggerOutN
);

	//////////////////////////////////////////////////////////////////////
	// decode helpers

	// grant per master number
	function [1:0] accessKind;
		input [3:0] mid;
		begin
			case (mid)
				`DTF_MID_CPU0:  accessKind = `DTF_ACC_SET;
				`DTF_MID_CPU1:  accessKind = `DTF_ACC_SET;
				`DTF_MID_DMA:   accessKind = `DTF_ACC_SET;
				`DTF_MID_DEBUG: accessKind = `DTF_ACC_CLR;
				default:        accessKind = `DTF_ACC_NONE;
			endcase
		end
	endfunction

	// read mux shared by crossbar and tool
	function [31:0] regRead;
		input [2:0]  idx;
		input [31:0] flagsV;
		input [31:0] presV;
		input        enV;
		begin
			case (idx)
				`DTF_IDX_FLAGS:    regRead = flagsV;
				`DTF_IDX_PRESENCE: regRead = presV;
				`DTF_IDX_ENABLE:   regRead = {31'h0, enV};
				`DTF_IDX_IDENT:    regRead = `DTF_IDENT_VALUE;
				default:           regRead = `DTF_WORD_ZERO;
			endcase
		end
	endfunction

	// index decode used by the crossbar port only
	function isMapped;
		input [2:0] idx;
		begin
			isMapped = (idx <= `DTF_IDX_IDENT);
		end
	endfunction

	//////////////////////////////////////////////////////////////////////
	// state

	reg  [31:0] flags;
	reg  [31:0] presence;
	reg         enable;
	reg  [31:0] next_flags;
	reg  [31:0] next_presence;
	reg  [31:0] setMask;
	reg  [31:0] clrMask;
	reg  [33:0] shiftIn;
	reg  [31:0] shiftOut;
	reg  [5:0]  bitCnt;
	reg         toolWr;

	wire [2:0]  pinLvl;
	wire [2:0]  pinRise;
	wire [1:0]  xbKind;
	wire        xbWrGo;
	wire        frameOn;
	wire        toolEdge;
	wire        hdrDone;
	wire [2:0]  hdrIdx;
	wire        toolWrGo;
	wire [2:0]  toolIdx;
	wire [31:0] toolData;

	//////////////////////////////////////////////////////////////////////
	// tool pin synchronisers

	dtf_pin_sync #(
		.WIDTH (3)
	) uSync (
		.clk   (clk),
		.srst  (srst),
		.pinIn ({toolDi, ~toolSelN, toolClk}),
		.level (pinLvl),
		.rise  (pinRise),
		.fall  ()
	);

	assign frameOn  = pinLvl[1];
	assign toolEdge = frameOn & pinRise[0];

	//////////////////////////////////////////////////////////////////////
	// tool frame decode

	// header is write bit then two index bits
	assign hdrDone  = toolEdge & (bitCnt == `DTF_HDR_LAST);
	assign hdrIdx   = {1'b0, shiftIn[0], pinLvl[2]};
	assign toolWrGo = toolEdge & (bitCnt == `DTF_FRAME_LAST) & toolWr;
	assign toolIdx  = {1'b0, shiftIn[32:31]};
	assign toolData = {shiftIn[30:0], pinLvl[2]};

	// a frame cut short just restarts; nothing is written
	always @(posedge clk) begin
		if (srst) begin
			bitCnt  <= `DTF_CNT_ZERO;
			shiftIn <= 34'h0;
			toolWr  <= 1'b0;
		end else if (!frameOn) begin
			bitCnt  <= `DTF_CNT_ZERO;
			toolWr  <= 1'b0;
		end else if (toolEdge) begin
			shiftIn <= {shiftIn[32:0], pinLvl[2]};
			// count parks past the last bit so extra bits write nothing
			if (bitCnt != `DTF_FRAME_DONE) begin
				bitCnt <= bitCnt + `DTF_CNT_ONE;
			end
			if (hdrDone) begin
				toolWr <= shiftIn[1];
			end
		end
	end

	// read data leaves msb first, one bit per tool clock
	always @(posedge clk) begin
		if (srst) begin
			shiftOut <= `DTF_WORD_ZERO;
			toolDo   <= 1'b0;
			toolDoEn <= 1'b0;
		end else begin
			toolDoEn <= frameOn;
			if (!frameOn) begin
				shiftOut <= `DTF_WORD_ZERO;
			end else if (hdrDone) begin
				shiftOut <= regRead(hdrIdx, flags, presence, enable);
			end else if (toolEdge) begin
				shiftOut <= {shiftOut[30:0], 1'b0};
			end
			toolDo <= shiftOut[31];
		end
	end

	//////////////////////////////////////////////////////////////////////
	// crossbar access

	assign xbKind = accessKind(xbMasterId);
	assign xbWrGo = xbReq & xbWrite & isMapped(xbAddr);

	// set wins over a clear landing in the same cycle
	always @* begin
		setMask = `DTF_WORD_ZERO;
		clrMask = `DTF_WORD_ZERO;
		next_presence = presence;
		if (xbWrGo && xbAddr == `DTF_IDX_FLAGS) begin
			if (xbKind == `DTF_ACC_SET && enable) begin
				setMask = xbWdata;
			end
			if (xbKind == `DTF_ACC_CLR) begin
				clrMask = xbWdata;
			end
		end
		if (toolWrGo && toolIdx == `DTF_IDX_FLAGS) begin
			clrMask = clrMask | toolData;
		end
		// zeros from cpu or dma leave bits alone
		next_flags = (flags & ~clrMask) | setMask;
		if (xbWrGo && xbAddr == `DTF_IDX_PRESENCE &&
			xbKind == `DTF_ACC_CLR) begin
			next_presence = xbWdata;
		end
		if (toolWrGo && toolIdx == `DTF_IDX_PRESENCE) begin
			next_presence = toolData;
		end
	end

	always @(posedge clk) begin
		if (srst) begin
			flags    <= `DTF_FLAGS_RST;
			presence <= `DTF_PRESENCE_RST;
			enable   <= `DTF_ENABLE_RST;
		end else begin
			flags    <= next_flags;
			presence <= next_presence;
			// any granted master may switch the feature
			if (xbWrGo && xbAddr == `DTF_IDX_ENABLE &&
				xbKind != `DTF_ACC_NONE) begin
				enable <= xbWdata[`DTF_EN_BIT];
			end
		end
	end

	// one answer per request; unmapped reads zero and flags an error
	always @(posedge clk) begin
		if (srst) begin
			xbAck   <= 1'b0;
			xbErr   <= 1'b0;
			xbRdata <= `DTF_WORD_ZERO;
		end else begin
			xbAck <= xbReq;
			xbErr <= xbReq & ~isMapped(xbAddr);
			if (xbReq && !xbWrite) begin
				xbRdata <= regRead(xbAddr, flags, presence, enable);
			end else begin
				xbRdata <= `DTF_WORD_ZERO;
			end
		end
	end

	//////////////////////////////////////////////////////////////////////
	// trigger pin

	// registered so the pin never glitches
	always @(posedge clk) begin
		if (srst) begin
			triggerOutN <= 1'b1;
		end else begin
			triggerOutN <= ~(enable & (|flags));
		end
	end

endmodule // dtf_trigger_semaphore

`default_nettype wire

// ### hdl/dtf_consts.vh
/*
 * constants for the development trigger flag block: register indices,
 * reset values, crossbar master numbers, access kinds, tool frame layout.
 * assumes it is included by bare name from the design files.
 */
`ifndef DTF_CONSTS_VH
`define DTF_CONSTS_VH

// register indices, shared by crossbar and tool frames
`define DTF_IDX_FLAGS      3'h0
`define DTF_IDX_PRESENCE   3'h1
`define DTF_IDX_ENABLE     3'h2
`define DTF_IDX_IDENT      3'h3

// enable register field
`define DTF_EN_BIT         0

// reset values
`define DTF_FLAGS_RST      32'h00000000
`define DTF_PRESENCE_RST   32'h00000000
`define DTF_ENABLE_RST     1'h0
`define DTF_WORD_ZERO      32'h00000000

// arbitrary identification value
`define DTF_IDENT_VALUE    32'h5A5A0001

// crossbar master numbers
`define DTF_MID_CPU0       4'h0
`define DTF_MID_CPU1       4'h1
`define DTF_MID_DMA        4'h4
`define DTF_MID_DEBUG      4'h8

// access kinds granted per master
`define DTF_ACC_NONE       2'h0
`define DTF_ACC_SET        2'h1
`define DTF_ACC_CLR        2'h2

// tool frame: 1 write bit, 2 index bits, 32 data bits
`define DTF_HDR_LAST       6'h02
`define DTF_FRAME_LAST     6'h22
`define DTF_FRAME_DONE     6'h23
`define DTF_CNT_ONE        6'h01
`define DTF_CNT_ZERO       6'h00

`endif

// ### hdl/dtf_pin_sync.v
/*
 * two-flop synchroniser with edge detection for a group of pins.
 * assumes the pins are asynchronous to clk and slower than clk/4.
 */
`timescale 1ns/1ps
`default_nettype none

module dtf_pin_sync #(
	parameter WIDTH = 3
) (
	// clock and reset
	input  wire             clk,
	input  wire             srst,
	// raw pins
	input  wire [WIDTH-1:0] pinIn,
	// synchronised view
	output wire [WIDTH-1:0] level,
	output wire [WIDTH-1:0] rise,
	output wire [WIDTH-1:0] fall
);

	reg [WIDTH-1:0] meta;
	reg [WIDTH-1:0] stable;
	reg [WIDTH-1:0] prior;

	genvar i;
	generate
		for (i = 0; i < WIDTH; i = i + 1) begin : gSync
			// meta feeds only stable; edges come from later stages
			always @(posedge clk) begin
				if (srst) begin
					meta[i]   <= 1'b0;
					stable[i] <= 1'b0;
					prior[i]  <= 1'b0;
				end else begin
					meta[i]   <= pinIn[i];
					stable[i] <= meta[i];
					prior[i]  <= stable[i];
				end
			end
			assign level[i] = stable[i];
			assign rise[i]  = stable[i] & ~prior[i];
			assign fall[i]  = ~stable[i] & prior[i];
		end
	endgenerate

endmodule // dtf_pin_sync

`default_nettype wire

// ### sim/dtf_trig_monitor.sv
/* assertions on the crossbar port and trigger pin.
   assumes it is bound into the trigger block. */
`timescale 1ns/1ps
`default_nettype none
`include "dtf_consts.vh"
module dtf_trig_monitor (
	// clock and reset
	input wire logic        clk,
	input wire logic        srst,
	// crossbar port
	input wire logic        xbReq,
	input wire logic        xbWrite,
	input wire logic [2:0]  xbAddr,
	input wire logic [31:0] xbWdata,
	input wire logic [3:0]  xbMasterId,
	input wire logic [31:0] xbRdata,
	input wire logic        xbAck,
	input wire logic        xbErr,
	// trigger
	input wire logic        triggerOutN,
	// tool pins
	input wire logic        toolSelN,
	input wire logic        toolDoEn
);
	logic en;
	wire  wr = xbReq && xbWrite;
	wire  cpuDma = xbMasterId == `DTF_MID_CPU0 ||
		xbMasterId == `DTF_MID_CPU1 || xbMasterId == `DTF_MID_DMA;
	// mirror of the enable bit, it is not visible at the ports
	always @(posedge clk) begin
		if (srst)
			en <= 1'h0;
		else if (wr && xbAddr == `DTF_IDX_ENABLE &&
			(cpuDma || xbMasterId == `DTF_MID_DEBUG))
			en <= xbWdata[0];
	end
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	sequence setReq;
		en && wr && cpuDma && xbAddr == `DTF_IDX_FLAGS && |xbWdata;
	endsequence
	sequence pinLow;
		##1 !triggerOutN;
	endsequence
	a_ack_follows: assert property (xbReq |=> xbAck)
		else $error("no ack after request");
	a_ack_cause: assert property (xbAck |-> $past(xbReq))
		else $error("ack without request");
	a_err_unmapped: assert property (xbReq && xbAddr[2] |=> xbErr)
		else $error("unmapped access without error");
	a_err_mapped: assert property (xbReq && !xbAddr[2] |=> !xbErr)
		else $error("error on mapped access");
	a_ident_read: assert property (xbReq && !xbWrite &&
		xbAddr == `DTF_IDX_IDENT |=> xbRdata == `DTF_IDENT_VALUE)
		else $error("wrong ident");
	a_rdata_idle: assert property (!xbAck |-> xbRdata == 32'h0)
		else $error("read data outside ack");
	a_trig_off: assert property (!en |=> triggerOutN)
		else $error("trigger low while off");
	a_trig_set: assert property (setReq |=> pinLow)
		else $error("trigger not low after set");
	a_doen_idle: assert property (toolSelN [*4] |-> !toolDoEn)
		else $error("tool data enable while idle");
	a_doen_frame: assert property (!toolSelN [*4] |-> toolDoEn)
		else $error("tool data enable missing in frame");
endmodule // dtf_trig_monitor
bind dtf_trigger_semaphore dtf_trig_monitor mon (.*);
`default_nettype wire

// ### sim/dtf_tool_model.sv
/* calibration tool on the serial debug pins.
   assumes the block samples the pins with its own clock. */
`timescale 1ns/1ps
`default_nettype none
module dtf_tool_model (
	// serial pins
	output logic toolClk,
	output logic toolSelN,
	output logic toolDi,
	input  wire logic toolDo
);
	initial {toolClk, toolSelN, toolDi} = 3'h2;
	// one frame; the clock stands still outside it
	task automatic frame(input logic w, input logic [1:0] idx,
		input logic [31:0] wd, output logic [31:0] rd);
		logic [34:0] s;
		s = {w, idx, wd};
		rd = '0;
		toolSelN = 1'h0;
		#160;
		for (int i = 34; i >= 0; i--) begin
			toolDi = s[i];
			#80;
			if (i < 32) rd = {rd[30:0], toolDo};
			toolClk = 1'h1;
			#80;
			toolClk = 1'h0;
		end
		#80;
		toolSelN = 1'h1;
		toolDi = ~toolDi; // released line shows no stale value
		#160;
	endtask
endmodule // dtf_tool_model
`default_nettype wire

// ### sim/test_dtf_trigger_semaphore.sv
/* self-checking bench for the trigger flag block.
   assumes the tool model and the monitor are compiled alongside. */
`timescale 1ns/1ps
`default_nettype none
`include "dtf_consts.vh"
module test_dtf_trigger_semaphore;
	logic        clk, srst, xbReq, xbWrite;
	logic [2:0]  xbAddr;
	logic [31:0] xbWdata, flags, rd, d;
	logic [3:0]  xbMasterId, id;
	logic [3:0]  ids [5] = '{4'h0, 4'h1, 4'h4, 4'h8, 4'h2};
	wire  [31:0] xbRdata;
	wire         xbAck, xbErr, toolClk, toolSelN, toolDi, toolDo;
	wire         triggerOutN;
	int          error_cnt = 0;
	int          n_compared = 0;
	dtf_trigger_semaphore uut (.clk(clk), .srst(srst), .xbReq(xbReq),
		.xbWrite(xbWrite), .xbAddr(xbAddr), .xbWdata(xbWdata),
		.xbMasterId(xbMasterId), .xbRdata(xbRdata), .xbAck(xbAck),
		.xbErr(xbErr), .toolClk(toolClk), .toolSelN(toolSelN),
		.toolDi(toolDi), .toolDo(toolDo), .toolDoEn(),
		.triggerOutN(triggerOutN));
	dtf_tool_model tool (.toolClk(toolClk), .toolSelN(toolSelN),
		.toolDi(toolDi), .toolDo(toolDo));
	initial begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end
	function automatic logic [31:0] nextFlags(input logic [31:0] f, w,
		input logic [3:0] m);
		if (m == `DTF_MID_DEBUG) return f & ~w;
		if (m == 4'h0 || m == 4'h1 || m == 4'h4) return f | w;
		return f;
	endfunction
	task automatic chk(input string n, input logic [31:0] e, g);
		n_compared++;
		if (g !== e) begin
			$display("[FAIL] %s expected %h seen %h", n, e, g);
			error_cnt++;
		end
	endtask
	task automatic xb(input logic w, input logic [2:0] a,
		input logic [31:0] wd, input logic [3:0] m);
		@(negedge clk);
		{xbReq, xbWrite, xbAddr, xbWdata, xbMasterId} = {1'h1, w, a, wd, m};
		@(negedge clk);
		xbReq = 1'h0;
		chk("err", {31'h0, a[2]}, {31'h0, xbErr});
		rd = xbRdata;
	endtask
	task automatic results;
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial begin
		void'($urandom(32'h191DAD5C));
		{xbReq, xbWrite, xbAddr, xbWdata, xbMasterId} = '0;
		srst = 1'h1;
		flags = '0;
		repeat (10) @(negedge clk);
		srst = 1'h0;
		for (int a = 0; a < 6; a++) begin
			xb(1'h0, a[2:0], '0, 4'h0);
			chk("reset", a == 3 ? `DTF_IDENT_VALUE : 32'h0, rd);
		end
		xb(1'h1, 3'h0, 32'h1, 4'h0);
		xb(1'h1, 3'h2, 32'h1, 4'h4);
		xb(1'h0, 3'h0, '0, 4'h0);
		chk("flags while off", 32'h0, rd);
		$display("test reset and enable done");
		for (int i = 0; i < 14; i++) begin
			d = $urandom & $urandom;
			id = ids[$urandom % 5];
			xb(1'h1, 3'h0, d, id);
			flags = nextFlags(flags, d, id);
			xb(1'h0, 3'h0, '0, 4'h0);
			chk("flags", flags, rd);
			chk("trig", {31'h0, ~|flags}, {31'h0, triggerOutN});
		end
		// switched off: flags stay, sets refused, pin released
		xb(1'h1, 3'h2, '0, 4'h1);
		xb(1'h1, 3'h0, ~flags, 4'h0);
		xb(1'h0, 3'h0, '0, 4'h4);
		chk("flags kept off", flags, rd);
		chk("trig off", 32'h1, {31'h0, triggerOutN});
		xb(1'h1, 3'h2, 32'h1, 4'h8);
		$display("test crossbar done");
		xb(1'h1, 3'h0, 32'h80000001, 4'h1);
		flags = flags | 32'h80000001;
		tool.frame(1'h0, 2'h0, '0, rd);
		chk("tool flags", flags, rd);
		tool.frame(1'h1, 2'h0, flags, rd);
		xb(1'h0, 3'h0, '0, 4'h0);
		chk("cleared", 32'h0, rd);
		chk("trigger off", 32'h1, {31'h0, triggerOutN});
		d = $urandom;
		tool.frame(1'h1, 2'h1, d, rd);
		xb(1'h1, 3'h1, ~d, 4'h0);
		xb(1'h0, 3'h1, '0, 4'h4);
		chk("presence", d, rd);
		xb(1'h1, 3'h1, ~d, 4'h8);
		xb(1'h0, 3'h1, '0, 4'h1);
		chk("presence debug", ~d, rd);
		tool.frame(1'h0, 2'h3, '0, rd);
		chk("tool ident", `DTF_IDENT_VALUE, rd);
		tool.frame(1'h1, 2'h2, '0, rd);
		xb(1'h0, 3'h2, '0, 4'h0);
		chk("enable kept", 32'h1, rd);
		$display("test tool done");
		srst = 1'h1;
		repeat (4) @(negedge clk);
		srst = 1'h0;
		xb(1'h0, 3'h2, '0, 4'h0);
		chk("enable reset", 32'h0, rd);
		chk("trig reset", 32'h1, {31'h0, triggerOutN});
		$display("test mid-run reset done");
		results;
	end
endmodule // test_dtf_trigger_semaphore
`default_nettype wire
